// [pkg/ppm_defines.svh]
// Register indices, field masks and reset values of the port function multiplexer
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
// Register indices; the byte address is four times the index
`define PPM_IDX_P0_FSEL 32'hFFFFF040
`define PPM_IDX_P1_FSEL 32'hFFFFF042
`define PPM_IDX_P0_ALT 32'hFFFFF580
`define PPM_IDX_P1_ALT 32'hFFFFF582
`define PPM_IDX_P0_LAT 32'hFFFFF000
`define PPM_IDX_P1_LAT 32'hFFFFF002
`define PPM_IDX_P0_PIN 32'hFFFFF004
`define PPM_IDX_P1_PIN 32'hFFFFF006
`define PPM_IDX_P0_DIR 32'hFFFFF020
`define PPM_IDX_P1_DIR 32'hFFFFF022
// Alternate-choice bits that exist; the low nibble is fixed to zero
`define PPM_ALT_MASK 8'hF0
// Reset values
`define PPM_RST_FSEL 8'h00
`define PPM_RST_ALT 8'h00
`define PPM_RST_DIR 8'hFF
`define PPM_RST_LAT 8'h00
// AXI responses
`define PPM_RESP_OKAY 2'h0
`define PPM_RESP_SLVERR 2'h2
`endif

// [pkg/ppm_pkg.sv]
// Types of the port function multiplexer
package ppm_pkg;

  // What a pin offers when its function-select bit is set
  typedef enum logic [1:0] {
    PPM_TMR_OUT,
    PPM_TMR_IN,
    PPM_ALT_IN,
    PPM_ALT_OUT
  } ppm_kind_e;

  // Register selector decoded from a word index
  typedef enum logic [3:0] {
    PPM_R_P0_FSEL,
    PPM_R_P1_FSEL,
    PPM_R_P0_ALT,
    PPM_R_P1_ALT,
    PPM_R_P0_DIR,
    PPM_R_P1_DIR,
    PPM_R_P0_LAT,
    PPM_R_P1_LAT,
    PPM_R_P0_PIN,
    PPM_R_P1_PIN,
    PPM_R_NONE
  } ppm_reg_e;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [29:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane0;
    logic [7:0] fsel0;
    logic [7:0] fsel1;
    logic [7:0] alt0;
    logic [7:0] alt1;
    logic [7:0] dir0;
    logic [7:0] dir1;
    logic [7:0] lat0;
    logic [7:0] lat1;
    logic [7:0] pout0;
    logic [7:0] poe0;
    logic [7:0] pout1;
    logic [7:0] poe1;
    logic g10_clr;
    logic g10_cap;
    logic [3:0] irq_a;
    logic [3:0] dreq;
    logic g11_clr;
    logic g11_cap;
    logic [3:0] irq_b;
  } ppm_state_s;

endpackage : ppm_pkg

// [rtl/ppm_pin_cell.sv]
// One pin: chooses between plain I/O and its peripheral function
`timescale 1ns/1ps
module ppm_pin_cell #(
  parameter ppm_pkg::ppm_kind_e KIND = ppm_pkg::PPM_TMR_OUT
) (
  // Configuration
  input wire logic fsel,
  input wire logic alt,
  input wire logic dir,
  input wire logic latch,
  // Peripheral side
  input wire logic periph_drive,
  output logic to_periph_a,
  output logic to_periph_b,
  // Pin side
  input wire logic pin_in,
  output logic pin_drive,
  output logic pin_oe
);

  always_comb
  begin
    // Plain I/O: latch drives when direction is output (0)
    pin_drive = latch;
    pin_oe = ~dir;
    to_periph_a = 1'b0;
    to_periph_b = 1'b0;
    if (fsel)
    begin
      unique case (KIND)
        ppm_pkg::PPM_TMR_OUT:
        begin
          pin_drive = periph_drive;
          pin_oe = 1'b1;
        end
        ppm_pkg::PPM_TMR_IN:
        begin
          pin_oe = 1'b0;
          to_periph_a = pin_in;
        end
        ppm_pkg::PPM_ALT_IN:
        begin
          pin_oe = 1'b0;
          to_periph_a = pin_in & ~alt;
          to_periph_b = pin_in & alt;
        end
        ppm_pkg::PPM_ALT_OUT:
        begin
          pin_oe = alt;
          pin_drive = alt ? periph_drive : latch;
          to_periph_a = pin_in & ~alt;
        end
      endcase
    end
  end

endmodule : ppm_pin_cell

// [rtl/ppm_top.sv]
// Function multiplexer for ports 0 and 1 with an AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Port 0 pins
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  // Port 1 pins
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  // Peripheral outputs that may reach pins
  input wire logic timer_g10_pulse_out_a,
  input wire logic timer_g10_pulse_out_b,
  input wire logic timer_g11_pulse_out_a,
  input wire logic timer_g11_pulse_out_b,
  input wire logic [3:0] dma_acknowledge_out,
  // Peripheral inputs fed from pins
  output logic timer_g10_counter_clear_in,
  output logic timer_g10_capture_in,
  output logic [3:0] ext_irq_a,
  output logic [3:0] dma_request_in,
  output logic timer_g11_counter_clear_in,
  output logic timer_g11_capture_in,
  output logic [3:0] ext_irq_b
);

  localparam logic [31:0] IDX_P0_FSEL = `PPM_IDX_P0_FSEL;
  localparam logic [31:0] IDX_P1_FSEL = `PPM_IDX_P1_FSEL;
  localparam logic [31:0] IDX_P0_ALT = `PPM_IDX_P0_ALT;
  localparam logic [31:0] IDX_P1_ALT = `PPM_IDX_P1_ALT;
  localparam logic [31:0] IDX_P0_DIR = `PPM_IDX_P0_DIR;
  localparam logic [31:0] IDX_P1_DIR = `PPM_IDX_P1_DIR;
  localparam logic [31:0] IDX_P0_LAT = `PPM_IDX_P0_LAT;
  localparam logic [31:0] IDX_P1_LAT = `PPM_IDX_P1_LAT;
  localparam logic [31:0] IDX_P0_PIN = `PPM_IDX_P0_PIN;
  localparam logic [31:0] IDX_P1_PIN = `PPM_IDX_P1_PIN;
  localparam logic [7:0] ALT_MASK = `PPM_ALT_MASK;

  ppm_pkg::ppm_state_s st_ff;
  ppm_pkg::ppm_state_s nxt_st;
  ppm_pkg::ppm_reg_e wsel;
  ppm_pkg::ppm_reg_e rsel;
  logic wr_go;
  logic [7:0] c0_drv;
  logic [7:0] c0_oe;
  logic [7:0] c0_ia;
  logic [7:0] c0_ib;
  logic [7:0] c1_drv;
  logic [7:0] c1_oe;
  logic [7:0] c1_ia;
  logic [7:0] c1_ib;
  logic [7:0] p0_periph;
  logic [7:0] p1_periph;

  // Word index to register; the upper two index bits fall off the 32-bit bus
  function automatic ppm_pkg::ppm_reg_e ppm_decode(input logic [29:0] idx);
    ppm_pkg::ppm_reg_e r;
    r = ppm_pkg::PPM_R_NONE;
    if (idx == IDX_P0_FSEL[29:0]) r = ppm_pkg::PPM_R_P0_FSEL;
    if (idx == IDX_P1_FSEL[29:0]) r = ppm_pkg::PPM_R_P1_FSEL;
    if (idx == IDX_P0_ALT[29:0]) r = ppm_pkg::PPM_R_P0_ALT;
    if (idx == IDX_P1_ALT[29:0]) r = ppm_pkg::PPM_R_P1_ALT;
    if (idx == IDX_P0_DIR[29:0]) r = ppm_pkg::PPM_R_P0_DIR;
    if (idx == IDX_P1_DIR[29:0]) r = ppm_pkg::PPM_R_P1_DIR;
    if (idx == IDX_P0_LAT[29:0]) r = ppm_pkg::PPM_R_P0_LAT;
    if (idx == IDX_P1_LAT[29:0]) r = ppm_pkg::PPM_R_P1_LAT;
    if (idx == IDX_P0_PIN[29:0]) r = ppm_pkg::PPM_R_P0_PIN;
    if (idx == IDX_P1_PIN[29:0]) r = ppm_pkg::PPM_R_P1_PIN;
    return r;
  endfunction : ppm_decode

  // Peripheral signals offered to each pin
  assign p0_periph = {6'h00, timer_g10_pulse_out_b, timer_g10_pulse_out_a};
  assign p1_periph = {dma_acknowledge_out, 2'h0, timer_g11_pulse_out_b, timer_g11_pulse_out_a};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      localparam ppm_pkg::ppm_kind_e K_LO = (gi < 2) ? ppm_pkg::PPM_TMR_OUT : ppm_pkg::PPM_TMR_IN;
      ppm_pin_cell #(
        .KIND((gi < 4) ? K_LO : ppm_pkg::PPM_ALT_IN)
      ) u_p0 (
        .fsel(st_ff.fsel0[gi]),
        .alt(st_ff.alt0[gi]),
        .dir(st_ff.dir0[gi]),
        .latch(st_ff.lat0[gi]),
        .periph_drive(p0_periph[gi]),
        .to_periph_a(c0_ia[gi]),
        .to_periph_b(c0_ib[gi]),
        .pin_in(port0_pin_in[gi]),
        .pin_drive(c0_drv[gi]),
        .pin_oe(c0_oe[gi])
      );
      ppm_pin_cell #(
        .KIND((gi < 4) ? K_LO : ppm_pkg::PPM_ALT_OUT)
      ) u_p1 (
        .fsel(st_ff.fsel1[gi]),
        .alt(st_ff.alt1[gi]),
        .dir(st_ff.dir1[gi]),
        .latch(st_ff.lat1[gi]),
        .periph_drive(p1_periph[gi]),
        .to_periph_a(c1_ia[gi]),
        .to_periph_b(c1_ib[gi]),
        .pin_in(port1_pin_in[gi]),
        .pin_drive(c1_drv[gi]),
        .pin_oe(c1_oe[gi])
      );
    end
  endgenerate

  always_comb
  begin
    nxt_st = st_ff;
    wsel = ppm_decode(st_ff.aw_idx);
    rsel = ppm_decode(araddr[31:2]);
    wr_go = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    // Address and data may arrive in either order
    if (awvalid && st_ff.awready)
    begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_idx = awaddr[31:2];
    end
    if (wvalid && st_ff.wready)
    begin
      nxt_st.w_have = 1'b1;
      nxt_st.wbyte = wdata[7:0];
      nxt_st.wlane0 = wstrb[0];
    end
    if (st_ff.bvalid && bready)
    begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wsel == ppm_pkg::PPM_R_NONE) ? `PPM_RESP_SLVERR : `PPM_RESP_OKAY;
      // Only byte lane 0 carries register bits; other lanes are ignored
      if (st_ff.wlane0)
      begin
        unique case (wsel)
          ppm_pkg::PPM_R_P0_FSEL: nxt_st.fsel0 = st_ff.wbyte;
          ppm_pkg::PPM_R_P1_FSEL: nxt_st.fsel1 = st_ff.wbyte;
          ppm_pkg::PPM_R_P0_ALT: nxt_st.alt0 = st_ff.wbyte & ALT_MASK;
          ppm_pkg::PPM_R_P1_ALT: nxt_st.alt1 = st_ff.wbyte & ALT_MASK;
          ppm_pkg::PPM_R_P0_DIR: nxt_st.dir0 = st_ff.wbyte;
          ppm_pkg::PPM_R_P1_DIR: nxt_st.dir1 = st_ff.wbyte;
          ppm_pkg::PPM_R_P0_LAT: nxt_st.lat0 = st_ff.wbyte;
          ppm_pkg::PPM_R_P1_LAT: nxt_st.lat1 = st_ff.wbyte;
          default: nxt_st.bresp = st_ff.bvalid ? st_ff.bresp : nxt_st.bresp;
        endcase
      end
    end
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;
    // Read answers at the edge that takes the address
    if (st_ff.rvalid && rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && st_ff.arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `PPM_RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      unique case (rsel)
        ppm_pkg::PPM_R_P0_FSEL: nxt_st.rdata[7:0] = st_ff.fsel0;
        ppm_pkg::PPM_R_P1_FSEL: nxt_st.rdata[7:0] = st_ff.fsel1;
        ppm_pkg::PPM_R_P0_ALT: nxt_st.rdata[7:0] = st_ff.alt0 & ALT_MASK;
        ppm_pkg::PPM_R_P1_ALT: nxt_st.rdata[7:0] = st_ff.alt1 & ALT_MASK;
        ppm_pkg::PPM_R_P0_DIR: nxt_st.rdata[7:0] = st_ff.dir0;
        ppm_pkg::PPM_R_P1_DIR: nxt_st.rdata[7:0] = st_ff.dir1;
        ppm_pkg::PPM_R_P0_LAT: nxt_st.rdata[7:0] = st_ff.lat0;
        ppm_pkg::PPM_R_P1_LAT: nxt_st.rdata[7:0] = st_ff.lat1;
        ppm_pkg::PPM_R_P0_PIN: nxt_st.rdata[7:0] = port0_pin_in;
        ppm_pkg::PPM_R_P1_PIN: nxt_st.rdata[7:0] = port1_pin_in;
        default: nxt_st.rresp = `PPM_RESP_SLVERR;
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid;
    // Pin and peripheral sides, registered once
    nxt_st.pout0 = c0_drv;
    nxt_st.poe0 = c0_oe;
    nxt_st.pout1 = c1_drv;
    nxt_st.poe1 = c1_oe;
    nxt_st.g10_clr = c0_ia[2];
    nxt_st.g10_cap = c0_ia[3];
    nxt_st.irq_a = c0_ia[7:4];
    nxt_st.dreq = c0_ib[7:4];
    nxt_st.g11_clr = c1_ia[2];
    nxt_st.g11_cap = c1_ia[3];
    nxt_st.irq_b = c1_ia[7:4];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.fsel0 <= `PPM_RST_FSEL;
      st_ff.fsel1 <= `PPM_RST_FSEL;
      st_ff.alt0 <= `PPM_RST_ALT;
      st_ff.alt1 <= `PPM_RST_ALT;
      st_ff.dir0 <= `PPM_RST_DIR;
      st_ff.dir1 <= `PPM_RST_DIR;
      st_ff.lat0 <= `PPM_RST_LAT;
      st_ff.lat1 <= `PPM_RST_LAT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rresp = st_ff.rresp;
  assign rdata = st_ff.rdata;
  assign port0_pin_out = st_ff.pout0;
  assign port0_pin_oe = st_ff.poe0;
  assign port1_pin_out = st_ff.pout1;
  assign port1_pin_oe = st_ff.poe1;
  assign timer_g10_counter_clear_in = st_ff.g10_clr;
  assign timer_g10_capture_in = st_ff.g10_cap;
  assign ext_irq_a = st_ff.irq_a;
  assign dma_request_in = st_ff.dreq;
  assign timer_g11_counter_clear_in = st_ff.g11_clr;
  assign timer_g11_capture_in = st_ff.g11_cap;
  assign ext_irq_b = st_ff.irq_b;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_alt0;
    wr_go && st_ff.wlane0 && (wsel == ppm_pkg::PPM_R_P0_ALT);
  endsequence

  sequence s_rd_alt0;
    arvalid && arready && (ppm_decode(araddr[31:2]) == ppm_pkg::PPM_R_P0_ALT);
  endsequence

  a_p0_pulse_a: assert property (st_ff.fsel0[0] |=>
    port0_pin_out[0] == $past(timer_g10_pulse_out_a) && port0_pin_oe[0])
    else $error("port0 pin0 not driven by group-10 pulse A");
  a_p0_pulse_b: assert property (st_ff.fsel0[1] |=>
    port0_pin_out[1] == $past(timer_g10_pulse_out_b) && port0_pin_oe[1])
    else $error("port0 pin1 not driven by group-10 pulse B");
  a_g10_clear_fwd: assert property (##1 timer_g10_counter_clear_in ==
    $past(port0_pin_in[2] & st_ff.fsel0[2]))
    else $error("group-10 counter clear not forwarded");
  a_g10_capture_fwd: assert property (st_ff.fsel0[3] |=>
    timer_g10_capture_in == $past(port0_pin_in[3]) && !port0_pin_oe[3])
    else $error("group-10 capture not forwarded");
  a_p0_irq_route: assert property (##1 ext_irq_a ==
    $past(port0_pin_in[7:4] & st_ff.fsel0[7:4] & ~st_ff.alt0[7:4]))
    else $error("port0 interrupt routing wrong");
  a_p0_dreq_route: assert property (##1 dma_request_in ==
    $past(port0_pin_in[7:4] & st_ff.fsel0[7:4] & st_ff.alt0[7:4]))
    else $error("port0 DMA request routing wrong");
  a_p0_io_ignores_alt: assert property (!st_ff.fsel0[6] |=>
    port0_pin_oe[6] == !$past(st_ff.dir0[6]) && !ext_irq_a[2] && !dma_request_in[2])
    else $error("port0 pin6 left plain I/O");
  a_alt0_write: assert property (s_wr_alt0 |=>
    st_ff.alt0 == ($past(st_ff.wbyte) & ALT_MASK) ##0 bvalid)
    else $error("alternate-choice 0 write lost");
  a_alt0_read: assert property (s_rd_alt0 |=>
    rvalid && rdata == {24'h000000, $past(st_ff.alt0) & ALT_MASK} && rdata[3:0] == 4'h0)
    else $error("alternate-choice 0 readback wrong");
  a_p1_direction: assert property (st_ff.fsel1 == 8'h00 |=>
    port1_pin_oe == ~$past(st_ff.dir1) && port1_pin_out == $past(st_ff.lat1))
    else $error("port1 direction not per pin");
  a_p1_pulse_out: assert property (st_ff.fsel1[0] && st_ff.fsel1[1] |=>
    port1_pin_out[1:0] == $past({timer_g11_pulse_out_b, timer_g11_pulse_out_a}))
    else $error("port1 pulse outputs wrong");
  a_p1_pulse_oe: assert property (st_ff.fsel1[1] |=> port1_pin_oe[1])
    else $error("port1 pin1 not enabled");
  a_g11_inputs: assert property (##1 {timer_g11_capture_in, timer_g11_counter_clear_in} ==
    $past(port1_pin_in[3:2] & st_ff.fsel1[3:2]))
    else $error("group-11 inputs not forwarded");
  a_g11_inputs_hiz: assert property (st_ff.fsel1[3] |=> !port1_pin_oe[3])
    else $error("port1 pin3 driven in capture mode");
  a_p1_ack_out: assert property (st_ff.fsel1[7] && st_ff.alt1[7] |=>
    port1_pin_out[7] == $past(dma_acknowledge_out[3]) && port1_pin_oe[7] && !ext_irq_b[3])
    else $error("port1 acknowledge output wrong");
  a_p1_irq_in: assert property (##1 ext_irq_b ==
    $past(port1_pin_in[7:4] & st_ff.fsel1[7:4] & ~st_ff.alt1[7:4]))
    else $error("port1 interrupt routing wrong");
  a_alt_low_zero: assert property (st_ff.alt0[3:0] == 4'h0 && st_ff.alt1[3:0] == 4'h0)
    else $error("alternate-choice low nibble set");
  a_wr_answer: assert property (wr_go |=> bvalid ##0 !awready[*1])
    else $error("write answer missing");

endmodule : ppm_top

// [sim/ppm_board.sv]
// Board model that sets the level of each pin of one 8-bit port
`timescale 1ns/1ps
module ppm_board (
  // Device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Level the board puts on pins that the device leaves undriven
  input wire logic [7:0] ext_level,
  // Level seen by the device
  output logic [7:0] pin_in
);
  // A driven pin shows the device's level, any other the board's
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule : ppm_board

// [sim/ppm_top_tb.sv]
// Self-checking testbench of the port function multiplexer
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, dma_acknowledge_out, ext_irq_a, dma_request_in, ext_irq_b;
  logic [1:0] bresp, rresp;
  logic [7:0] port0_pin_in, port0_pin_out, port0_pin_oe, port1_pin_in, port1_pin_out, port1_pin_oe;
  logic [7:0] ext0, ext1, e;
  logic timer_g10_pulse_out_a, timer_g10_pulse_out_b, timer_g11_pulse_out_a, timer_g11_pulse_out_b;
  logic timer_g10_counter_clear_in, timer_g10_capture_in, timer_g11_counter_clear_in, timer_g11_capture_in;
  logic [31:0] d;
  logic [1:0] r;
  logic b;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] idx_tab [8] = '{`PPM_IDX_P0_FSEL, `PPM_IDX_P1_FSEL, `PPM_IDX_P0_ALT, `PPM_IDX_P1_ALT,
    `PPM_IDX_P0_DIR, `PPM_IDX_P1_DIR, `PPM_IDX_P0_LAT, `PPM_IDX_P1_LAT};
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};

  ppm_top ppm_top_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .port0_pin_in, .port0_pin_out, .port0_pin_oe, .port1_pin_in, .port1_pin_out, .port1_pin_oe,
    .timer_g10_pulse_out_a, .timer_g10_pulse_out_b, .timer_g11_pulse_out_a, .timer_g11_pulse_out_b,
    .dma_acknowledge_out, .timer_g10_counter_clear_in, .timer_g10_capture_in, .ext_irq_a,
    .dma_request_in, .timer_g11_counter_clear_in, .timer_g11_capture_in, .ext_irq_b
  );
  ppm_board ppm_board_inst0 (.pin_out(port0_pin_out), .pin_oe(port0_pin_oe), .ext_level(ext0),
    .pin_in(port0_pin_in));
  ppm_board ppm_board_inst1 (.pin_out(port1_pin_out), .pin_oe(port1_pin_oe), .ext_level(ext1),
    .pin_in(port1_pin_in));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Byte address of a register index, truncated to the bus width
  function automatic logic [31:0] ba(input logic [31:0] idx);
    return idx << 2;
  endfunction : ba

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n >= 100) failures++;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    v = 32'hFFFFFFFF;
    resp = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n >= 100) failures++;
  endtask : axi_rd

  // Config reaches the pins one edge later and the peripheral inputs one more
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h00000000;
    araddr = 32'h00000000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    ext0 = 8'h00;
    ext1 = 8'h00;
    {timer_g10_pulse_out_a, timer_g10_pulse_out_b, timer_g11_pulse_out_a, timer_g11_pulse_out_b} = 4'h0;
    dma_acknowledge_out = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      axi_rd(ba(idx_tab[i]), d, r);
      chk(d, {24'h000000, rst_tab[i]});
    end
    // Unmapped word
    axi_rd(32'h00000010, d, r);
    chk({d[29:0], r}, {30'h0, `PPM_RESP_SLVERR});
    axi_wr(32'h00000010, 8'hFF, r);
    chk(r, `PPM_RESP_SLVERR);
    axi_wr(ba(`PPM_IDX_P0_ALT), 8'hFF, r);
    axi_rd(ba(`PPM_IDX_P0_ALT), d, r);
    chk(d, 32'h000000F0);
    axi_wr(ba(`PPM_IDX_P1_ALT), 8'hFF, r);
    axi_rd(ba(`PPM_IDX_P1_ALT), d, r);
    chk(d, 32'h000000F0);
    // Single-bit clear by read-modify-write
    axi_rd(ba(`PPM_IDX_P0_ALT), d, r);
    axi_wr(ba(`PPM_IDX_P0_ALT), d[7:0] & 8'hBF, r);
    axi_rd(ba(`PPM_IDX_P0_ALT), d, r);
    chk(d, 32'h000000B0);
    axi_wr(ba(`PPM_IDX_P0_ALT), 8'h30, r);
    axi_wr(ba(`PPM_IDX_P1_ALT), 8'hC0, r);
    axi_wr(ba(`PPM_IDX_P0_DIR), 8'hF0, r);
    axi_wr(ba(`PPM_IDX_P0_LAT), 8'hA5, r);
    ext0 <= 8'hF0;
    ext1 <= 8'hF0;
    settle();
    chk(port0_pin_oe, 32'h0000000F);
    chk(port0_pin_out & port0_pin_oe, 32'h00000005);
    chk({ext_irq_a, dma_request_in}, 32'h00000000);
    chk({port1_pin_oe, ext_irq_b}, 32'h00000000);
    // Driven pins read back the latch, released pins the board level
    axi_rd(ba(`PPM_IDX_P0_PIN), d, r);
    chk(d, 32'h000000F5);
    axi_wr(ba(`PPM_IDX_P0_FSEL), 8'hFF, r);
    axi_wr(ba(`PPM_IDX_P1_FSEL), 8'hFF, r);
    for (int i = 0; i < 2; i++)
    begin
      e = i ? 8'hA5 : 8'h5A;
      b = i[0];
      ext0 <= e;
      ext1 <= e;
      timer_g10_pulse_out_a <= b;
      timer_g10_pulse_out_b <= ~b;
      timer_g11_pulse_out_a <= ~b;
      timer_g11_pulse_out_b <= b;
      dma_acknowledge_out <= e[3:0];
      settle();
      chk(port0_pin_oe, 32'h00000003);
      chk(port0_pin_out[1:0], {30'h0, ~b, b});
      chk(timer_g10_counter_clear_in, e[2]);
      chk(timer_g10_capture_in, e[3]);
      chk(ext_irq_a, e[7:4] & 4'hC);
      chk(dma_request_in, e[7:4] & 4'h3);
      chk(port1_pin_oe, 32'h000000C3);
      chk(port1_pin_out & 8'hC3, {e[3:2], 4'h0, b, ~b});
      chk(timer_g11_counter_clear_in, e[2]);
      chk(timer_g11_capture_in, e[3]);
      chk(ext_irq_b, e[7:4] & 4'h3);
    end
    axi_wr(ba(`PPM_IDX_P1_FSEL), 8'h00, r);
    axi_wr(ba(`PPM_IDX_P1_DIR), 8'h3C, r);
    axi_wr(ba(`PPM_IDX_P1_LAT), 8'hA5, r);
    settle();
    chk(port1_pin_oe, 32'h000000C3);
    chk(port1_pin_out & 8'hC3, 32'h00000081);
    chk({ext_irq_b, timer_g11_counter_clear_in, timer_g11_capture_in}, 32'h00000000);
    tally_and_finish();
  end
endmodule : ppm_top_tb
